// [logic/hps_defines.svh]
// timing constants for the handset power-up sequencer
// assumes a 20 MHz system clock; times in their own units
`ifndef HPS_DEFINES_SVH
`define HPS_DEFINES_SVH
`define HPS_CLK_HZ        20000000
`define HPS_DEBOUNCE_MS   32
`define HPS_LDO_STD_US    125
`define HPS_LDO_OPT_MS    10
`define HPS_RESET_MS      20
`define HPS_HOLDUP_MS     500
`define HPS_FLAG_MAX_US   10
// cycle counts derived from the times above
`define HPS_DEBOUNCE_CYC  (`HPS_DEBOUNCE_MS * (`HPS_CLK_HZ / 1000))
`define HPS_LDO_STD_CYC   (`HPS_LDO_STD_US * (`HPS_CLK_HZ / 1000000))
`define HPS_LDO_OPT_CYC   (`HPS_LDO_OPT_MS * (`HPS_CLK_HZ / 1000))
`define HPS_RESET_CYC     (`HPS_RESET_MS * (`HPS_CLK_HZ / 1000))
`define HPS_HOLDUP_CYC    (`HPS_HOLDUP_MS * (`HPS_CLK_HZ / 1000))
`define HPS_FLAG_CYC      (`HPS_FLAG_MAX_US * (`HPS_CLK_HZ / 1000000) / 2)
`endif

// [logic/hps_pkg.sv]
// types for the handset power-up sequencer
// assumes nothing beyond the defines header
package hps_pkg;
	typedef enum logic [3:0] {
		ST_OFF    = 4'h0,
		ST_REG1   = 4'h1,
		ST_GAP12  = 4'h3,
		ST_REG2   = 4'h2,
		ST_RSTDLY = 4'h6,
		ST_HOLDUP = 4'h7,
		ST_ON     = 4'h5,
		ST_DN2    = 4'h4,
		ST_DN1    = 4'hc
	} hps_state_type;
endpackage

// [logic/hps_flag_if.sv]
// interface carrying the two regulator good flags and the enables
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface hps_flag_if;
	logic [1:0] reg_en;
	logic [1:0] good;
	modport seq (output reg_en, input good);
	modport mon (input reg_en, output good);
endinterface

// [logic/hps_flag_filter.sv]
// good-flag filters: comparator levels synchronised and delayed
// assumes raw comparator levels (above 95% / above 90%) from analog
`timescale 1ns/10ps
`include "hps_defines.svh"
module hps_flag_filter
#(
	parameter int FLAG_CYC = `HPS_FLAG_CYC
)
(
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic [1:0] above_rise_i,
	input  wire logic [1:0] above_fall_i,
	hps_flag_if.mon         flags
);
	////////////////////////////////////////////////////////////////
	// per regulator: hysteresis then a bounded settle delay
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_flag
			logic [1:0] sync_hi;
			logic [1:0] sync_lo;
			logic       raw;
			logic       good;
			logic [7:0] cnt;
			// two-flop synchronisers for analog comparator levels
			always_ff @(posedge sys_clk_i)
			begin
				sync_hi <= {sync_hi[0], above_rise_i[g]};
				sync_lo <= {sync_lo[0], above_fall_i[g]};
			end
			// hysteresis: set at 95 %, clear below 90 %
			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i)
					raw <= 1'b0;
				else if (sync_hi[1])
					raw <= 1'b1;
				else if (!sync_lo[1])
					raw <= 1'b0;
			end
			// flag follows raw after a fixed delay under 10 us
			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i)
				begin
					good <= 1'b0;
					cnt  <= 8'h00;
				end
				else if (raw == good)
					cnt <= 8'h00;
				else if (cnt >= 8'(FLAG_CYC - 1))
				begin
					good <= raw;
					cnt  <= 8'h00;
				end
				else
					cnt <= cnt + 8'h01;
			end
			assign flags.good[g] = good;
		end
	endgenerate
endmodule

// [logic/hps_sequencer.sv]
// handset power-up / power-down sequencer, top level
// assumes pins are asynchronous; comparators supply raw levels
`timescale 1ns/10ps
`include "hps_defines.svh"
module hps_sequencer
	import hps_pkg::*;
#(
	parameter int  DEBOUNCE_CYC = `HPS_DEBOUNCE_CYC,
	parameter int  RESET_CYC    = `HPS_RESET_CYC,
	parameter int  HOLDUP_CYC   = `HPS_HOLDUP_CYC,
	parameter int  LDO_OPT_CYC  = `HPS_LDO_OPT_CYC,
	parameter bit  LDO_OPTIONAL = 1'b0
)
(
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic       key_press_in_i,
	input  wire logic       charger_detect_n_i,
	input  wire logic       keep_alive_in_i,
	input  wire logic [1:0] flag_rise_threshold_i,
	input  wire logic [1:0] flag_fall_threshold_i,
	output logic [1:0]      regulator_en_o,
	output logic            cpu_reset_n_o,
	output logic            wake_req_n_o,
	output logic            wake_req_oe_n_o
);
	import hps_pkg::*;
	localparam int LDO_CYC = LDO_OPTIONAL ? LDO_OPT_CYC
		: `HPS_LDO_STD_CYC;

	hps_flag_if    fl ();
	hps_state_type state;
	logic [1:0]    key_s;
	logic [1:0]    chg_s;
	logic [1:0]    ka_s;
	logic          key_db;
	logic          chg_db;
	logic          key_db_d;
	logic [24:0]   key_cnt;
	logic [24:0]   chg_cnt;
	logic [24:0]   tmr;
	logic          wake;
	logic          next_wake;
	logic          shut;

	////////////////////////////////////////////////////////////////
	// good-flag generation
	hps_flag_filter u_flags (
		.sys_clk_i    (sys_clk_i),
		.srst_i       (srst_i),
		.above_rise_i (flag_rise_threshold_i),
		.above_fall_i (flag_fall_threshold_i),
		.flags        (fl.mon)
	);

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge sys_clk_i)
	begin
		key_s <= {key_s[0], key_press_in_i};
		chg_s <= {chg_s[0], charger_detect_n_i};
		ka_s  <= {ka_s[0], keep_alive_in_i};
	end

	// debounce: level must stand unchanged for the full interval
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			key_db  <= 1'b0;
			key_cnt <= '0;
		end
		else if (key_s[1] == key_db)
			key_cnt <= '0;
		else if (key_cnt >= 25'(DEBOUNCE_CYC - 1))
		begin
			key_db  <= key_s[1];
			key_cnt <= '0;
		end
		else
			key_cnt <= key_cnt + 25'h1;
	end

	// charger debounce, active low input, reset value inactive
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			chg_db  <= 1'b0;
			chg_cnt <= '0;
		end
		else if (!chg_s[1] == chg_db)
			chg_cnt <= '0;
		else if (chg_cnt >= 25'(DEBOUNCE_CYC - 1))
		begin
			chg_db  <= !chg_s[1];
			chg_cnt <= '0;
		end
		else
			chg_cnt <= chg_cnt + 25'h1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			key_db_d <= 1'b0;
		else
			key_db_d <= key_db;
	end

	// shutdown request: keep-alive low without charger, or flag loss
	assign shut = (!ka_s[1] && !chg_db)
		|| (fl.good != 2'b11);

	////////////////////////////////////////////////////////////////
	// sequencer, with one shared interval timer
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state <= ST_OFF;
			tmr   <= '0;
		end
		else
		begin
			tmr <= tmr + 25'h1;
			case (state)
			ST_OFF:
				if ((key_db && !key_db_d) || chg_db)
					state <= ST_REG1;
			ST_REG1:
				if (fl.good[0])
				begin
					state <= ST_GAP12;
					tmr   <= '0;
				end
			ST_GAP12:
				if (!fl.good[0])
					state <= ST_DN1;
				else if (tmr >= 25'(LDO_CYC - 1))
					state <= ST_REG2;
			ST_REG2:
				if (fl.good == 2'b11)
				begin
					state <= ST_RSTDLY;
					tmr   <= '0;
				end
				else if (!fl.good[0])
				begin
					state <= ST_DN2;
					tmr   <= '0;
				end
			ST_RSTDLY:
				if (fl.good != 2'b11)
				begin
					state <= ST_DN2;
					tmr   <= '0;
				end
				else if (tmr >= 25'(RESET_CYC - 1))
				begin
					state <= ST_HOLDUP;
					tmr   <= '0;
				end
			ST_HOLDUP:
				if (fl.good != 2'b11)
				begin
					state <= ST_DN2;
					tmr   <= '0;
				end
				else if (ka_s[1])
					state <= ST_ON;
				else if (tmr >= 25'(HOLDUP_CYC - 1) && !chg_db)
				begin
					state <= ST_DN2;
					tmr   <= '0;
				end
				else if (tmr >= 25'(HOLDUP_CYC - 1))
					state <= ST_ON;
			ST_ON:
				if (shut)
				begin
					state <= ST_DN2;
					tmr   <= '0;
				end
			ST_DN2:
				if (tmr >= 25'(RESET_CYC - 1))
					state <= ST_DN1;
			ST_DN1:
				if (fl.good[1])
					tmr <= '0;
				else if (tmr >= 25'(LDO_CYC - 1) && !fl.reg_en[1])
					state <= ST_OFF;
			default:
				state <= ST_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			fl.reg_en     <= 2'b00;
			cpu_reset_n_o <= 1'b0;
			regulator_en_o <= 2'b00;
		end
		else
		begin
			fl.reg_en[0] <= !(state == ST_OFF)
				&& !(state == ST_DN1 && !fl.good[1]
				&& tmr >= 25'(LDO_CYC - 1));
			fl.reg_en[1] <= (state == ST_REG2) || (state == ST_RSTDLY)
				|| (state == ST_HOLDUP) || (state == ST_ON)
				|| (state == ST_DN2 && tmr < 25'(RESET_CYC - 1));
			cpu_reset_n_o <= (state == ST_HOLDUP && fl.good == 2'b11
				&& (ka_s[1] || chg_db || tmr < 25'(HOLDUP_CYC - 1)))
				|| (state == ST_ON && !shut)
				|| (state == ST_RSTDLY && fl.good == 2'b11
				&& tmr >= 25'(RESET_CYC - 1));
			regulator_en_o <= fl.reg_en;
		end
	end

	// wake request from key acceptance until keep-alive or window end;
	// dropped on every way down so it never outlives a failed start
	always_comb
	begin
		next_wake = wake;
		if (state == ST_OFF && key_db && !key_db_d)
			next_wake = 1'b1;
		else if (state == ST_ON || state == ST_DN2 || state == ST_DN1
			|| state == ST_OFF)
			next_wake = 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			wake <= 1'b0;
		else
			wake <= next_wake;
	end

	// open drain: line only ever pulled low, enable low while driving
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			wake_req_n_o    <= 1'b0;
			wake_req_oe_n_o <= 1'b1;
		end
		else
		begin
			wake_req_n_o    <= 1'b0;
			wake_req_oe_n_o <= !next_wake;
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	property p_reset_needs_flags;
		@(posedge sys_clk_i) disable iff (srst_i)
		$rose(cpu_reset_n_o) |-> $past(fl.good) == 2'b11;
	endproperty
	a_reset_needs_flags: assert property (p_reset_needs_flags)
		else $error("reset released without both good flags");

	property p_flag_loss_drops_reset;
		@(posedge sys_clk_i) disable iff (srst_i)
		(cpu_reset_n_o && fl.good != 2'b11) |=> !cpu_reset_n_o;
	endproperty
	a_flag_loss_drops_reset: assert property (p_flag_loss_drops_reset)
		else $error("reset held high after good flag loss");

	property p_reg2_after_reg1;
		@(posedge sys_clk_i) disable iff (srst_i)
		$rose(fl.reg_en[1]) |-> fl.good[0] && fl.reg_en[0];
	endproperty
	a_reg2_after_reg1: assert property (p_reg2_after_reg1)
		else $error("second regulator enabled before first good");

	property p_gap_waits;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state == ST_GAP12 && tmr < 25'(LDO_CYC - 1)) |=> !fl.reg_en[1];
	endproperty
	a_gap_waits: assert property (p_gap_waits)
		else $error("second regulator enabled early");

	property p_reg2_off_delay;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state == ST_DN2 && tmr == 25'h0) |=> fl.reg_en[1];
	endproperty
	a_reg2_off_delay: assert property (p_reg2_off_delay)
		else $error("second regulator dropped before reset delay");

	property p_reg1_last;
		@(posedge sys_clk_i) disable iff (srst_i)
		$fell(fl.reg_en[0]) |-> !fl.reg_en[1] && !fl.good[1];
	endproperty
	a_reg1_last: assert property (p_reg1_last)
		else $error("first regulator off before second");

	property p_wake_only_from_key;
		@(posedge sys_clk_i) disable iff (srst_i)
		$fell(wake_req_oe_n_o) |-> $past(key_db) && !$past(key_db_d);
	endproperty
	a_wake_only_from_key: assert property (p_wake_only_from_key)
		else $error("wake request without key press");

	property p_wake_release;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state == ST_ON) |=> ##1 wake_req_oe_n_o;
	endproperty
	a_wake_release: assert property (p_wake_release)
		else $error("wake request held after keep-alive");

	property p_od_low;
		@(posedge sys_clk_i) disable iff (srst_i)
		!wake_req_oe_n_o |-> !wake_req_n_o && state != ST_OFF;
	endproperty
	a_od_low: assert property (p_od_low)
		else $error("open drain driving high");

	property p_off_no_reg;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state == ST_OFF) [*2] |-> fl.reg_en == 2'b00;
	endproperty
	a_off_no_reg: assert property (p_off_no_reg)
		else $error("regulator on while off");

	c_powered_up: cover property (@(posedge sys_clk_i) state == ST_ON);
	c_holdup_fail: cover property (@(posedge sys_clk_i)
		state == ST_HOLDUP ##1 state == ST_DN2);
	c_back_off: cover property (@(posedge sys_clk_i)
		state == ST_DN1 ##1 state == ST_OFF);
endmodule

// [tb/hps_cpu_model.sv]
// partner model: processor keep-alive plus regulator output comparators
// assumes enables and processor reset come from the sequencer, one clock
`timescale 1ns/10ps
module hps_cpu_model
(
	input  wire logic        sys_clk_i,
	input  wire logic [1:0]  regulator_en_i,
	input  wire logic        cpu_reset_n_i,
	input  wire logic [1:0]  brown_i,
	input  wire logic [15:0] ka_delay_i,
	input  wire logic        ka_drop_i,
	output logic [1:0]       above_rise_o,
	output logic [1:0]       above_fall_o,
	output logic             keep_alive_o
);
	logic [7:0]  ramp0 = 8'h00;
	logic [7:0]  ramp1 = 8'h00;
	logic [15:0] up_cnt = 16'h0000;

	////////////////////////////////////////////////////////////////////
	// output ramps: 90% level leads 95% going up and trails it going down
	always_ff @(posedge sys_clk_i)
	begin
		ramp0 <= {ramp0[6:0], regulator_en_i[0] & ~brown_i[0]};
		ramp1 <= {ramp1[6:0], regulator_en_i[1] & ~brown_i[1]};
	end
	assign above_rise_o = {&ramp1[7:3], &ramp0[7:3]};
	assign above_fall_o = {|ramp1[7:3], |ramp0[7:3]};

	////////////////////////////////////////////////////////////////////
	// keep-alive raised a set time after reset release, dropped on request
	always_ff @(posedge sys_clk_i)
	begin
		if (!cpu_reset_n_i)
			up_cnt <= 16'h0000;
		else if (up_cnt != 16'hffff)
			up_cnt <= up_cnt + 16'h0001;
		keep_alive_o <= cpu_reset_n_i && up_cnt >= ka_delay_i
			&& !ka_drop_i;
	end
endmodule

// [tb/hps_sequencer_tb_top.sv]
// testbench for the power sequencer with a processor partner model
// assumes short parameter values so every interval is at most 100 cycles
`timescale 1ns/10ps
module hps_sequencer_tb_top;
	localparam int DEB = 16;
	localparam int RST = 40;
	localparam int HOLD = 100;
	localparam int LDO = 20;
	localparam int FLG = 100;
	typedef struct {
		logic        k;
		logic        c;
		logic [15:0] d;
		logic        on;
	} hps_row_type;
	hps_row_type rows [3] = '{
		'{1'b1, 1'b0, 16'h0005, 1'b1},
		'{1'b1, 1'b0, 16'hffff, 1'b0},
		'{1'b0, 1'b1, 16'hffff, 1'b1}};
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        key = 1'b0;
	logic        chg_n = 1'b1;
	logic [1:0]  brown = 2'h0;
	logic [15:0] ka_dly = 16'hffff;
	logic        ka_drop = 1'b0;
	logic [1:0]  rise;
	logic [1:0]  fall;
	logic [1:0]  en;
	logic        ka;
	logic        rst_n;
	logic        wake;
	logic        wake_oe_n;
	logic [4:0]  mon;
	int          mismatches = 0;
	int          check_count = 0;
	int          n;

	////////////////////////////////////////////////////////////////////
	// clock, design and partner
	always #25 sys_clk = ~sys_clk;
	assign mon = {wake_oe_n, rst_n, en, ka};
	hps_sequencer #(.DEBOUNCE_CYC(DEB), .RESET_CYC(RST), .HOLDUP_CYC(HOLD),
		.LDO_OPT_CYC(LDO), .LDO_OPTIONAL(1'b1)) uut (.sys_clk_i(sys_clk),
		.srst_i(srst), .key_press_in_i(key), .charger_detect_n_i(chg_n),
		.keep_alive_in_i(ka), .flag_rise_threshold_i(rise),
		.flag_fall_threshold_i(fall), .regulator_en_o(en),
		.cpu_reset_n_o(rst_n), .wake_req_n_o(wake),
		.wake_req_oe_n_o(wake_oe_n));
	hps_cpu_model cpu (.sys_clk_i(sys_clk), .regulator_en_i(en),
		.cpu_reset_n_i(rst_n), .brown_i(brown), .ka_delay_i(ka_dly),
		.ka_drop_i(ka_drop), .above_rise_o(rise), .above_fall_o(fall),
		.keep_alive_o(ka));

	////////////////////////////////////////////////////////////////////
	// comparison, waiting and closing tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic span(input int lo, input int hi);
		check(16'(n), (n >= lo && n <= hi) ? 16'(n) : 16'(lo));
	endtask
	task automatic wait_bit(input int b, input logic v, input int max);
		n = 0;
		while (mon[b] !== v && n < max)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (mon[b] !== v)
		begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic do_reset();
		srst = 1'b1;
		ka_drop = 1'b0;
		brown = 2'h0;
		chg_n = 1'b1;
		repeat (10) @(posedge sys_clk);
		#1 srst = 1'b0;
	endtask
	// start from off and time each step of the power-up order
	task automatic power_up(input logic k, input logic c);
		key = k;
		chg_n = ~c;
		wait_bit(1, 1'b1, DEB + 20);
		span(DEB, DEB + 8);
		check(wake_oe_n, {15'h0, ~k});
		check(wake, 1'b0);
		key = 1'b0;
		wait_bit(2, 1'b1, LDO + FLG + 40);
		span(LDO + FLG, LDO + FLG + 16);
		wait_bit(3, 1'b1, RST + FLG + 40);
		span(RST + FLG, RST + FLG + 16);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence: reset, table of start-ups, then the awkward cases
	initial
	begin
		repeat (6) @(posedge sys_clk);
		#1 srst = 1'b0;
		check({en, rst_n, wake_oe_n}, 16'h1);
		key = 1'b1;
		repeat (DEB - 4) @(posedge sys_clk);
		#1 key = 1'b0;
		repeat (DEB + 20) @(posedge sys_clk);
		#1 check({en, wake_oe_n}, 16'h1);
		foreach (rows[i])
		begin
			do_reset();
			ka_dly = rows[i].d;
			power_up(rows[i].k, rows[i].c);
			if (rows[i].on)
			begin
				repeat (HOLD + 20) @(posedge sys_clk);
				#1 check(rst_n, 1'b1);
			end
			else
			begin
				wait_bit(3, 1'b0, HOLD + 20);
				span(HOLD, HOLD + 4);
				wait_bit(1, 1'b0, RST + LDO + 2 * FLG);
			end
			check(wake_oe_n, 1'b1);
		end
		// charger holds power on with keep-alive never raised, then removal
		chg_n = 1'b0;
		repeat (DEB + 20) @(posedge sys_clk);
		#1 chg_n = 1'b1;
		wait_bit(3, 1'b0, DEB + 20);
		wait_bit(2, 1'b0, RST + 10);
		span(RST, RST + 4);
		wait_bit(1, 1'b0, LDO + FLG + 40);
		span(LDO + FLG, LDO + FLG + 20);
		// keep-alive drop without charger shuts down at once
		do_reset();
		ka_dly = 16'h0005;
		power_up(1'b1, 1'b0);
		wait_bit(0, 1'b1, 20);
		ka_drop = 1'b1;
		wait_bit(3, 1'b0, 8);
		span(1, 5);
		// key ignored while on, then a regulator sags
		do_reset();
		power_up(1'b1, 1'b0);
		key = 1'b1;
		repeat (DEB + 10) @(posedge sys_clk);
		#1 key = 1'b0;
		check({rst_n, wake_oe_n}, 16'h3);
		brown = 2'h2;
		wait_bit(3, 1'b0, FLG + 30);
		span(FLG, FLG + 16);
		test_done();
	end
endmodule
